/* src/balu_core.sv */
/*
  byte alu datapath with its operand, result and flag registers behind an
  avalon-mm slave with waitrequest.
  assumes a single 250 MHz core_clk, synchronous active-high reset and a master
  that holds each request until it sees waitrequest low.
*/
`timescale 1ns/1ps
`default_nettype none

module balu_core
  import balu_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [DATA_W-1:0] avs_readdata,
  output logic                   avs_waitrequest,
  // status towards control logic
  output logic                   busy,
  output logic                   op_done
);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_EXEC  = 2'b01,
    ST_EXEC2 = 2'b10
  } balu_state_t;

  balu_state_t  state_reg;
  balu_op_t     op_reg;
  logic [7:0]   dest_reg;
  logic [7:0]   src_reg;
  logic [7:0]   imm_reg;
  logic [7:0]   pair_hi_reg;
  logic [7:0]   prod_lo_reg;
  logic [7:0]   prod_hi_reg;
  balu_flags_t  flags_reg;
  balu_flags_t  flags_next;
  logic         done_reg;
  logic         rd_ready_reg;
  logic [31:0]  rdata_reg;
  logic [31:0]  rdata_next;
  logic         wr_take;
  logic         rd_take;
  logic         lane0;
  logic         commit;
  logic         op_legal;
  balu_result_t res;

  // arithmetic path operands
  logic [7:0]   op_a;
  logic [7:0]   op_b;
  logic         cin;
  logic         is_sub;
  logic [8:0]   sum9;
  logic [4:0]   nib5;
  logic         ar_v;
  logic [15:0]  word_in;
  logic [15:0]  word_res;
  logic [15:0]  prod;
  balu_flags_t  f_arith;
  balu_flags_t  f_word;

  // bus handshake: writes take one cycle, reads one wait state, all stall while busy
  assign busy            = (state_reg != ST_IDLE);
  assign op_done         = done_reg;
  assign lane0           = avs_byteenable[0];
  assign wr_take         = avs_write & ~busy;
  assign rd_take         = avs_read & ~busy & rd_ready_reg;
  assign avs_waitrequest = (avs_write & busy) | (avs_read & ~rd_take);
  assign avs_readdata    = rdata_reg;

  always_comb begin
    op_legal = 1'b1;
    unique case (avs_writedata[4:0])
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07,
      5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f,
      5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16: op_legal = 1'b1;
      default: op_legal = 1'b0;
    endcase
  end

  // operand selection for the shared adder
  always_comb begin
    op_a   = dest_reg;
    op_b   = src_reg;
    cin    = 1'b0;
    is_sub = 1'b0;
    unique case (op_reg)
      OP_SUM_WITH_CARRY_IN:      cin = flags_reg.borrow_out_bit;
      OP_DIFFERENCE_REGS:        is_sub = 1'b1;
      OP_DIFFERENCE_IMM: begin
        op_b   = imm_reg;
        is_sub = 1'b1;
      end
      OP_DIFFERENCE_WITH_BORROW: begin
        cin    = flags_reg.borrow_out_bit;
        is_sub = 1'b1;
      end
      OP_DIFFERENCE_IMM_BORROW: begin
        op_b   = imm_reg;
        cin    = flags_reg.borrow_out_bit;
        is_sub = 1'b1;
      end
      OP_ARITH_INVERSE: begin
        op_a   = BYTE_ZERO;
        op_b   = dest_reg;
        is_sub = 1'b1;
      end
      OP_PLUS_ONE:               op_b = BYTE_ONE;
      OP_MINUS_ONE: begin
        op_b   = BYTE_ONE;
        is_sub = 1'b1;
      end
      default: begin
        op_a   = dest_reg;
        op_b   = src_reg;
        cin    = 1'b0;
        is_sub = 1'b0;
      end
    endcase
  end

  // nine and five bit sums keep the carries; the stored byte drops bit 8
  always_comb begin
    if (is_sub) begin
      sum9 = {1'b0, op_a} - {1'b0, op_b} - {8'h00, cin};
      nib5 = {1'b0, op_a[3:0]} - {1'b0, op_b[3:0]} - {4'h0, cin};
      ar_v = (op_a[7] & ~op_b[7] & ~sum9[7]) | (~op_a[7] & op_b[7] & sum9[7]);
    end else begin
      sum9 = {1'b0, op_a} + {1'b0, op_b} + {8'h00, cin};
      nib5 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]} + {4'h0, cin};
      ar_v = (op_a[7] & op_b[7] & ~sum9[7]) | (~op_a[7] & ~op_b[7] & sum9[7]);
    end
    f_arith.borrow_out_bit     = sum9[8];
    f_arith.result_null_flag   = (sum9[7:0] == BYTE_ZERO);
    f_arith.msb_result_flag    = sum9[7];
    f_arith.signed_wrap_flag   = ar_v;
    f_arith.true_polarity_flag = sum9[7] ^ ar_v;
    f_arith.nibble_carry       = nib5[4];
  end

  // word path and product
  always_comb begin
    word_in = {pair_hi_reg, dest_reg};
    if (op_reg == OP_WORD_MINUS_IMM) begin
      word_res = word_in - {8'h00, imm_reg};
      f_word.signed_wrap_flag = pair_hi_reg[7] & ~word_res[15];
      f_word.borrow_out_bit   = word_res[15] & ~pair_hi_reg[7];
    end else begin
      word_res = word_in + {8'h00, imm_reg};
      f_word.signed_wrap_flag = ~pair_hi_reg[7] & word_res[15];
      f_word.borrow_out_bit   = ~word_res[15] & pair_hi_reg[7];
    end
    f_word.result_null_flag   = (word_res == 16'h0000);
    f_word.msb_result_flag    = word_res[15];
    f_word.true_polarity_flag = word_res[15] ^ f_word.signed_wrap_flag;
    f_word.nibble_carry       = 1'b0;
    prod = {8'h00, dest_reg} * {8'h00, src_reg};
  end

  // per-operation result, written back flags and long/short length
  always_comb begin
    res         = '0;
    res.lo      = dest_reg;
    res.hi      = pair_hi_reg;
    res.flags   = f_arith;
    res.mask    = MASK_ARITH;
    res.wr_lo   = 1'b1;
    res.long_op = 1'b0;
    unique case (op_reg)
      OP_SUM_TWO_REGS, OP_SUM_WITH_CARRY_IN, OP_DIFFERENCE_REGS, OP_DIFFERENCE_IMM,
      OP_DIFFERENCE_WITH_BORROW, OP_DIFFERENCE_IMM_BORROW, OP_ARITH_INVERSE: begin
        res.lo = sum9[7:0];
      end
      OP_WORD_PLUS_IMM, OP_WORD_MINUS_IMM: begin
        res.lo      = word_res[7:0];
        res.hi      = word_res[15:8];
        res.wr_hi   = 1'b1;
        res.flags   = f_word;
        res.mask    = MASK_WORD;
        res.long_op = 1'b1;
      end
      OP_BITWISE_CONJ_REGS:   res.lo = dest_reg & src_reg;
      OP_BITWISE_CONJ_IMM:    res.lo = dest_reg & imm_reg;
      OP_BITWISE_DISJ_REGS:   res.lo = dest_reg | src_reg;
      OP_BITWISE_DISJ_IMM:    res.lo = dest_reg | imm_reg;
      OP_SET_SELECTED_BITS:   res.lo = dest_reg | imm_reg;
      OP_CLEAR_SELECTED_BITS: res.lo = dest_reg & (BYTE_ONES - imm_reg);
      OP_BITWISE_XOR_REGS:    res.lo = dest_reg ^ src_reg;
      OP_ZERO_MINUS_TEST:     res.lo = dest_reg & dest_reg;
      OP_ZERO_REGISTER:       res.lo = dest_reg ^ dest_reg;
      OP_INVERT_BITS:         res.lo = BYTE_ONES - dest_reg;
      OP_PLUS_ONE, OP_MINUS_ONE: begin
        res.lo = sum9[7:0];
        res.mask = MASK_LOGIC;
      end
      OP_ALL_ONES_REGISTER: begin
        res.lo   = BYTE_ONES;
        res.mask = MASK_NONE;
      end
      OP_UNSIGNED_PRODUCT: begin
        res.wr_lo   = 1'b0;
        res.wr_prod = 1'b1;
        res.lo      = prod[7:0];
        res.hi      = prod[15:8];
        res.flags.result_null_flag = (prod == 16'h0000);
        res.flags.borrow_out_bit   = prod[15];
        res.mask    = MASK_PROD;
        res.long_op = 1'b1;
      end
      default: res.wr_lo = 1'b0;
    endcase
    // logic class: zero, sign and cleared overflow
    unique case (op_reg)
      OP_BITWISE_CONJ_REGS, OP_BITWISE_CONJ_IMM, OP_BITWISE_DISJ_REGS, OP_BITWISE_DISJ_IMM,
      OP_BITWISE_XOR_REGS, OP_SET_SELECTED_BITS, OP_CLEAR_SELECTED_BITS,
      OP_ZERO_MINUS_TEST, OP_ZERO_REGISTER, OP_INVERT_BITS: begin
        res.flags.result_null_flag = (res.lo == BYTE_ZERO);
        res.flags.msb_result_flag  = res.lo[7];
        res.flags.signed_wrap_flag = 1'b0;
        res.mask = (op_reg == OP_INVERT_BITS) ? MASK_INV : MASK_LOGIC;
        res.flags.borrow_out_bit   = 1'b1;
      end
      default: res.mask = res.mask;
    endcase
  end

  // commit at the last execution cycle
  assign commit = ((state_reg == ST_EXEC) & ~res.long_op) | (state_reg == ST_EXEC2);
  assign flags_next = balu_flags_t'((flags_reg & ~res.mask) | (res.flags & res.mask));

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
      op_reg    <= OP_SUM_TWO_REGS;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (wr_take & lane0 & (avs_address == OFS_CTRL) & op_legal) begin
            op_reg    <= balu_op_t'(avs_writedata[4:0]);
            state_reg <= ST_EXEC;
          end
        end
        ST_EXEC:  state_reg <= res.long_op ? ST_EXEC2 : ST_IDLE;
        ST_EXEC2: state_reg <= ST_IDLE;
        default:  state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= commit;
    end
  end

  // operand and result registers: software writes when idle, the alu at commit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dest_reg    <= RST_BYTE;
      src_reg     <= RST_BYTE;
      imm_reg     <= RST_BYTE;
      pair_hi_reg <= RST_BYTE;
      prod_lo_reg <= RST_BYTE;
      prod_hi_reg <= RST_BYTE;
      flags_reg   <= RST_FLAGS;
    end else if (commit) begin
      if (res.wr_lo) begin
        dest_reg <= res.lo;
      end
      if (res.wr_hi) begin
        pair_hi_reg <= res.hi;
      end
      if (res.wr_prod) begin
        prod_lo_reg <= res.lo;
        prod_hi_reg <= res.hi;
      end
      flags_reg <= flags_next;
    end else if (wr_take & lane0) begin
      unique case (avs_address)
        OFS_DEST:    dest_reg    <= avs_writedata[7:0];
        OFS_SRC:     src_reg     <= avs_writedata[7:0];
        OFS_IMM:     imm_reg     <= avs_writedata[7:0];
        OFS_PAIR_HI: pair_hi_reg <= avs_writedata[7:0];
        OFS_PROD_LO: prod_lo_reg <= avs_writedata[7:0];
        OFS_PROD_HI: prod_hi_reg <= avs_writedata[7:0];
        OFS_FLAGS:   flags_reg   <= balu_flags_t'(avs_writedata[5:0]);
        default:     flags_reg   <= flags_reg;
      endcase
    end
  end

  // read data is captured one cycle ahead of the answer
  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      OFS_CTRL: begin
        rdata_next[CTRL_BUSY_BIT] = busy;
        rdata_next[CTRL_OP_LSB +: 5] = op_reg;
      end
      OFS_DEST:    rdata_next[7:0] = dest_reg;
      OFS_SRC:     rdata_next[7:0] = src_reg;
      OFS_IMM:     rdata_next[7:0] = imm_reg;
      OFS_PAIR_HI: rdata_next[7:0] = pair_hi_reg;
      OFS_FLAGS:   rdata_next[5:0] = flags_reg;
      OFS_PROD_LO: rdata_next[7:0] = prod_lo_reg;
      OFS_PROD_HI: rdata_next[7:0] = prod_hi_reg;
      default:     rdata_next = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_ready_reg <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
    end else if (avs_read & ~busy & ~rd_ready_reg) begin
      rd_ready_reg <= 1'b1;
      rdata_reg    <= rdata_next;
    end else begin
      rd_ready_reg <= 1'b0;
    end
  end

endmodule : balu_core

`default_nettype wire

/* src/balu_pkg.sv */
/*
  package of the byte alu: register offsets, field positions, reset values,
  operation codes, flag layout and the structs that carry a result.
  assumes a 32-bit avalon-mm slave with byte addresses, one word per register.
*/
package balu_pkg;

  // bus shape
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 32;

  // register byte offsets
  localparam logic [5:0] OFS_CTRL    = 6'h00;
  localparam logic [5:0] OFS_DEST    = 6'h04;
  localparam logic [5:0] OFS_SRC     = 6'h08;
  localparam logic [5:0] OFS_IMM     = 6'h0c;
  localparam logic [5:0] OFS_PAIR_HI = 6'h10;
  localparam logic [5:0] OFS_FLAGS   = 6'h14;
  localparam logic [5:0] OFS_PROD_LO = 6'h18;
  localparam logic [5:0] OFS_PROD_HI = 6'h1c;

  // ctrl field positions
  localparam int unsigned CTRL_BUSY_BIT = 0;
  localparam int unsigned CTRL_OP_LSB   = 8;

  // reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [5:0] RST_FLAGS = 6'h00;

  // execution lengths in core clock cycles
  localparam logic [1:0] CYC_SHORT = 2'h1;
  localparam logic [1:0] CYC_LONG  = 2'h2;

  // constants of the operations
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE  = 8'h01;

  typedef enum logic [4:0] {
    OP_SUM_TWO_REGS            = 5'h00,
    OP_SUM_WITH_CARRY_IN       = 5'h01,
    OP_WORD_PLUS_IMM           = 5'h02,
    OP_DIFFERENCE_REGS         = 5'h03,
    OP_DIFFERENCE_IMM          = 5'h04,
    OP_DIFFERENCE_WITH_BORROW  = 5'h05,
    OP_DIFFERENCE_IMM_BORROW   = 5'h06,
    OP_WORD_MINUS_IMM          = 5'h07,
    OP_BITWISE_CONJ_REGS       = 5'h08,
    OP_BITWISE_CONJ_IMM        = 5'h09,
    OP_BITWISE_DISJ_REGS       = 5'h0a,
    OP_BITWISE_DISJ_IMM        = 5'h0b,
    OP_BITWISE_XOR_REGS        = 5'h0c,
    OP_INVERT_BITS             = 5'h0d,
    OP_ARITH_INVERSE           = 5'h0e,
    OP_SET_SELECTED_BITS       = 5'h0f,
    OP_CLEAR_SELECTED_BITS     = 5'h10,
    OP_PLUS_ONE                = 5'h11,
    OP_MINUS_ONE               = 5'h12,
    OP_ZERO_MINUS_TEST         = 5'h13,
    OP_ZERO_REGISTER           = 5'h14,
    OP_ALL_ONES_REGISTER       = 5'h15,
    OP_UNSIGNED_PRODUCT        = 5'h16
  } balu_op_t;

  // flag word, bit 0 is borrow_out_bit
  typedef struct packed {
    logic nibble_carry;
    logic true_polarity_flag;
    logic signed_wrap_flag;
    logic msb_result_flag;
    logic result_null_flag;
    logic borrow_out_bit;
  } balu_flags_t;

  // which flags an operation class touches
  localparam logic [5:0] MASK_ARITH = 6'h2f;
  localparam logic [5:0] MASK_LOGIC = 6'h0e;
  localparam logic [5:0] MASK_INV   = 6'h0f;
  localparam logic [5:0] MASK_WORD  = 6'h1f;
  localparam logic [5:0] MASK_PROD  = 6'h03;
  localparam logic [5:0] MASK_NONE  = 6'h00;

  typedef struct packed {
    logic [7:0]  lo;
    logic [7:0]  hi;
    balu_flags_t flags;
    logic [5:0]  mask;
    logic        wr_lo;
    logic        wr_hi;
    logic        wr_prod;
    logic        long_op;
  } balu_result_t;

endpackage : balu_pkg

/* verification/balu_core_asserts.sv */
/*
  checker of the byte alu: busy, done and bus wait timing at the top ports.
  assumes it is bound to balu_core and sees the same core_clk and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module balu_core_asserts
  import balu_pkg::*;
(
  // clock and reset
  input wire logic              core_clk,
  input wire logic              reset,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic              avs_waitrequest,
  // status
  input wire logic              busy,
  input wire logic              op_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  logic       go;
  logic [4:0] code;
  assign go   = avs_write && !avs_waitrequest && avs_address == OFS_CTRL && avs_byteenable[0];
  assign code = avs_writedata[4:0];
  sequence s_run1; busy ##1 !busy && op_done; endsequence
  sequence s_run2; busy [*2] ##1 !busy && op_done; endsequence
  a_short_op_len: assert property (go && code <= 5'h15 && code != 5'h02 && code != 5'h07 |=> s_run1)
    else $error("short op did not take one cycle");
  a_word_op_len: assert property (go && (code == 5'h02 || code == 5'h07) |=> s_run2)
    else $error("word op did not take two cycles");
  a_prod_op_len: assert property (go && code == 5'h16 |=> s_run2)
    else $error("product did not take two cycles");
  a_bad_code_idle: assert property (go && code > 5'h16 |=> !busy && !op_done)
    else $error("illegal code started an operation");
  a_done_pulse_once: assert property (op_done |=> !op_done)
    else $error("done held longer than one cycle");
  a_done_after_busy: assert property (op_done |-> $past(busy) && !busy)
    else $error("done without a finished operation");
  a_bus_stall_busy: assert property (busy && (avs_read || avs_write) |-> avs_waitrequest)
    else $error("access not stalled while busy");
  a_read_wait_one: assert property (avs_read && !busy && !$past(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("idle read not answered after one wait");
  a_write_no_wait: assert property (avs_write && !busy |-> !avs_waitrequest)
    else $error("idle write stalled");
endmodule : balu_core_asserts
bind balu_core balu_core_asserts u_asserts (
  .core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .op_done(op_done)
);
`default_nettype wire

/* verification/balu_ctrl_model.sv */
/*
  control model of the byte alu: avalon-mm master standing in for decode logic.
  assumes one clock and a slave that answers through waitrequest.
*/
`timescale 1ns/1ps
`default_nettype none
module balu_ctrl_model
  import balu_pkg::*;
(
  // clock
  input  wire logic              core_clk,
  // avalon-mm master
  output var  logic [ADDR_W-1:0] avs_address,
  output var  logic              avs_read,
  output var  logic              avs_write,
  output var  logic [DATA_W-1:0] avs_writedata,
  output var  logic [3:0]        avs_byteenable,
  input  wire logic [DATA_W-1:0] avs_readdata,
  input  wire logic              avs_waitrequest
);
  initial begin
    avs_address    = '0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = '0;
    avs_byteenable = 4'h0;
  end
  // request held until an edge samples waitrequest low
  task automatic access(input logic [5:0] a, input logic wr, input logic [31:0] d,
                        input logic [3:0] be, output logic [31:0] q);
    @(posedge core_clk);
    avs_address    <= a;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do @(posedge core_clk); while (avs_waitrequest);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : access
endmodule : balu_ctrl_model
`default_nettype wire

/* verification/testbench.sv */
/*
  testbench of the byte alu: reference model compared after every operation of the opcode sweep, after the back to back pair as a whole.
  assumes balu_core, balu_ctrl_model and the bound checker are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import balu_pkg::*;
  logic              core_clk = 1'b0;
  logic              reset    = 1'b1;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest, busy, op_done;
  logic [DATA_W-1:0] avs_writedata, avs_readdata, q, v, f;
  logic [3:0]        avs_byteenable;
  logic [7:0]        m_d, m_s, m_k, m_h, m_pl = 8'h00, m_ph = 8'h00;
  logic [5:0]        m_f;
  logic [31:0]       fixed [2] = '{32'h7f0101ff, 32'h80808080};
  int                errors = 0, check_count = 0, cycles = 0, seed = 32'h340c;

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      conclude();
    end
  end

  balu_core uut (.core_clk(core_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .busy(busy), .op_done(op_done));
  balu_ctrl_model u_ctrl (.core_clk(core_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    u_ctrl.access(a, 1'b1, {24'h0, d}, 4'hf, q);
  endtask : wr
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
    u_ctrl.access(a, 1'b0, 32'h0, 4'hf, q);
    check(q, {24'h0, e});
  endtask : rd_chk
  task automatic zn(input int r);
    m_d    = r[7:0];
    m_f[1] = (r[7:0] == 8'h00);
    m_f[2] = r[7];
  endtask : zn
  task automatic lg(input int r);
    zn(r);
    m_f[3] = 1'b0;
  endtask : lg
  task automatic arith(input int a, input int b, input int ci, input bit sub);
    int r;
    r = sub ? a - b - ci : a + b + ci;
    zn(r);
    m_f[0] = sub ? (b + ci > a) : (r > 255);
    m_f[5] = sub ? (b % 16 + ci > a % 16) : (a % 16 + b % 16 + ci > 15);
    m_f[3] = sub ? ((a ^ b) & (a ^ r) & 128) != 0 : ((a ^ r) & (b ^ r) & 128) != 0;
  endtask : arith
  task automatic model(input int op);
    int c, w;
    c = m_f[0];
    case (op)
      0: arith(m_d, m_s, 0, 0);
      1: arith(m_d, m_s, c, 0);
      3: arith(m_d, m_s, 0, 1);
      4: arith(m_d, m_k, 0, 1);
      5: arith(m_d, m_s, c, 1);
      6: arith(m_d, m_k, c, 1);
      2, 7: begin
        w      = (op == 2) ? {m_h, m_d} + m_k : {m_h, m_d} - m_k;
        m_d    = w[7:0];
        m_f[1] = (w[15:0] == 16'h0);
        m_f[2] = w[15];
        m_f[3] = (op == 2) ? (!m_h[7] && w[15]) : (m_h[7] && !w[15]);
        m_f[0] = (op == 2) ? (m_h[7] && !w[15]) : (!m_h[7] && w[15]);
        m_f[4] = m_f[2] ^ m_f[3];
        m_h    = w[15:8];
      end
      8: lg(m_d & m_s);
      9: lg(m_d & m_k);
      10: lg(m_d | m_s);
      11, 15: lg(m_d | m_k);
      12: lg(m_d ^ m_s);
      13: begin
        lg(8'hff - m_d);
        m_f[0] = 1'b1;
      end
      14: arith(0, m_d, 0, 1);
      16: lg(m_d & (8'hff - m_k));
      17: begin
        lg(m_d + 1);
        m_f[3] = (m_d == 8'h80);
      end
      18: begin
        lg(m_d - 1);
        m_f[3] = (m_d == 8'h7f);
      end
      19: lg(m_d);
      20: lg(0);
      21: m_d = 8'hff;
      22: begin
        w          = m_d * m_s;
        {m_ph, m_pl} = w[15:0];
        m_f[1]     = (w == 0);
        m_f[0]     = w[15];
      end
      default: ;
    endcase
  endtask : model
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    for (int a = 0; a < 9; a++) rd_chk(6'(a * 4), 8'h00);
    for (int op = 0; op < 32; op++) begin
      for (int it = 0; it < 4; it++) begin
        v = (it < 2) ? fixed[it] : $random(seed);
        f = $random(seed);
        {m_d, m_s, m_k, m_h} = v;
        m_f = f[5:0];
        wr(OFS_DEST, m_d);
        wr(OFS_SRC, m_s);
        wr(OFS_IMM, m_k);
        wr(OFS_PAIR_HI, m_h);
        wr(OFS_FLAGS, {2'b00, m_f});
        wr(OFS_CTRL, 8'(op));
        model(op);
        rd_chk(OFS_DEST, m_d);
        rd_chk(OFS_PAIR_HI, m_h);
        rd_chk(OFS_FLAGS, {2'b00, m_f});
        rd_chk(OFS_PROD_LO, m_pl);
        rd_chk(OFS_PROD_HI, m_ph);
      end
    end
    // back to back operations, the short first one already finished when the second is issued
    wr(OFS_CTRL, 8'h11);
    wr(OFS_CTRL, 8'h11);
    model(17);
    model(17);
    rd_chk(OFS_DEST, m_d);
    u_ctrl.access(OFS_DEST, 1'b1, 32'h5a, 4'he, q);
    rd_chk(OFS_DEST, m_d);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    rd_chk(OFS_DEST, 8'h00);
    rd_chk(OFS_PROD_LO, 8'h00);
    conclude();
  end
endmodule : testbench
`default_nettype wire
